// ### rtl/ifcu_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ifcu_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### rtl/ifcu_pkg.sv
// types shared by the calibration store target
package ifcu_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } ifcu_state_e;
endpackage

// ### rtl/ifcu_regs.svh
// offsets, field layouts and timing counts of the calibration store and serial target
`ifndef IFCU_REGS_SVH
`define IFCU_REGS_SVH

// ============================================================
// clock and timing
`define IFCU_CLK_MHZ          100
`define IFCU_FETCH_US         80
`define IFCU_FETCH_CYCLES     (`IFCU_FETCH_US * `IFCU_CLK_MHZ)

// ============================================================
// calibration store geometry
`define IFCU_WORD_W           16
`define IFCU_ADDR_W           5
`define IFCU_DEPTH            32

// ============================================================
// calibration store word offsets
`define IFCU_TGT_ADDR_WORD    5'h02
`define IFCU_CAL_UPPER_P      5'h03
`define IFCU_CAL_UPPER_T      5'h04
`define IFCU_PRESS_B_LOW      5'h05
`define IFCU_PRESS_A_LOW      5'h06
`define IFCU_PRESS_D_LOW      5'h07
`define IFCU_PRESS_E_LOW      5'h08
`define IFCU_PRESS_G_LOW      5'h09
`define IFCU_PRESS_F_LOW      5'h0A
`define IFCU_PRESS_C_LOW      5'h0B
`define IFCU_TEMP_B_LOW       5'h0C
`define IFCU_TEMP_A_LOW       5'h0D
`define IFCU_TEMP_C_LOW       5'h0E
`define IFCU_PRESS_H_LOW      5'h0F
`define IFCU_PRESS_BA_MID     5'h10
`define IFCU_PRESS_DE_MID     5'h11
`define IFCU_PRESS_FG_MID     5'h12
`define IFCU_PRESS_C_MID      5'h13

// ============================================================
// writable-bit masks, reserved bits held at zero
`define IFCU_UPPER_P_MASK     16'hBFFF
`define IFCU_UPPER_T_MASK     16'h003F
`define IFCU_C_MID_MASK       16'hFF00
`define IFCU_FULL_MASK        16'hFFFF

// ============================================================
// serial target addressing and status byte
`define IFCU_DEF_TGT_ADDR     7'h78
`define IFCU_ST_POWER_BIT     6
`define IFCU_ST_BUSY_BIT      5
`define IFCU_ST_CRC_BIT       2
`define IFCU_FILL_BYTE        8'h00

`endif

// ### rtl/ifcu_target_top.sv
// calibration store behind a serial target port, with status-first reads
//
// Behaviour
// [R1] host filter: new = (old*(coef-1) + raw) / coef.
// [R2] host filters raw samples before compensation, not after.
// [R3] host coefficient is 1, 2, 4, 8 or 16; 1 passes raw through.
// [R4] host holds previous raw temperature when a temperature measurement is skipped.
// [R5] host re-initialises filter state when the coefficient changes.
// [R6] host keeps per-channel state, loaded with the first raw sample after init.
// [R7] calibration store is a set of 16-bit words selected by word address.
// [R8] store holds eleven coefficients: three temperature, eight pressure.
// [R9] words 3 and 4 hold upper coefficient bits; reserved bits ignored.
// [R10] words 5..0x13 hold low and middle coefficient bits in fixed order.
// [R11] host concatenates fragments into 26, 17 and 18 bit coefficients.
// [R12] host sign-extends each assembled coefficient as two's complement.
// [R13] target port works at standard-mode and fast-mode speeds.
// [R14] target never holds the clock line low; clock pin is input only.
// [R15] target answers address 0x78 by default.
// [R16] low seven bits of word 0x02 replace the response address.
// [R17] host keeps measurement interval constant while filtering.
// [R18] word address written, 80 us wait, then read returns status and two bytes.
// [R19] every read returns the status byte first.
`timescale 1ns/1ps
`default_nettype none
`include "ifcu_regs.svh"
module ifcu_target_top #(
    parameter int FETCH_CYCLES = `IFCU_FETCH_CYCLES,
    parameter int FIFO_DEPTH   = 4
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe,
    input  wire logic                      adc_powered,
    input  wire logic                      store_crc_error,
    input  wire logic                      prog_we,
    input  wire logic [`IFCU_ADDR_W-1:0]   prog_addr,
    input  wire logic [`IFCU_WORD_W-1:0]   prog_data,
    output logic                           fetch_busy
);
    // ============================================================
    // pin synchronisers; clock is sampled only, never driven
    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
        end else begin
            scl_s1_reg <= scl_i; // [R14]
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    // 100 MHz sampling leaves many samples per fast-mode bit, so no glitch filter is kept
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s2_reg && !scl_s3_reg; // [R13]
    assign scl_fall  = !scl_s2_reg && scl_s3_reg;
    assign bus_start = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
    assign bus_stop  = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;

    // ============================================================
    // calibration store, one 16-bit word per address
    logic [`IFCU_WORD_W-1:0] store_mem [`IFCU_DEPTH]; // [R7]
    logic                    addr_prog_reg;
    logic [`IFCU_WORD_W-1:0] prog_mask;

    always_comb begin
        case (prog_addr)
            `IFCU_CAL_UPPER_P: prog_mask = `IFCU_UPPER_P_MASK; // [R9]
            `IFCU_CAL_UPPER_T: prog_mask = `IFCU_UPPER_T_MASK; // [R9]
            `IFCU_PRESS_C_MID: prog_mask = `IFCU_C_MID_MASK;   // [R10]
            default:           prog_mask = `IFCU_FULL_MASK;
        endcase
    end

    // eleven coefficients live in words 3..0x13 laid out as the fixed table
    always_ff @(posedge clk) begin
        if (prog_we) begin
            store_mem[prog_addr] <= prog_data & prog_mask; // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_prog_reg <= 1'b0;
        end else if (prog_we && prog_addr == `IFCU_TGT_ADDR_WORD) begin
            addr_prog_reg <= 1'b1;
        end
    end

    logic [6:0] tgt_addr;
    assign tgt_addr = addr_prog_reg ? store_mem[`IFCU_TGT_ADDR_WORD][6:0] // [R16]
                                    : `IFCU_DEF_TGT_ADDR;                 // [R15]

    // ============================================================
    // serial target state
    ifcu_pkg::ifcu_state_e state_reg;
    logic [7:0]            rx_sh_reg;
    logic [7:0]            tx_sh_reg;
    logic [3:0]            bit_cnt_reg;
    logic                  rw_reg;
    logic                  first_reg;
    logic [1:0]            tx_idx_reg;
    logic                  sda_oe_reg;
    logic                  push_valid_reg;
    logic [8:0]            push_data_reg;
    logic                  fifo_in_ready;
    logic                  busy_reg;
    logic [`IFCU_WORD_W-1:0] data_reg;
    logic [7:0]            status_byte;
    logic [7:0]            tx_byte;
    logic                  addr_hit;

    always_comb begin
        status_byte = 8'h00;
        status_byte[`IFCU_ST_POWER_BIT] = adc_powered;
        status_byte[`IFCU_ST_BUSY_BIT]  = busy_reg;
        status_byte[`IFCU_ST_CRC_BIT]   = store_crc_error;
    end

    always_comb begin
        case (tx_idx_reg)
            2'h0:    tx_byte = status_byte;    // [R19]
            2'h1:    tx_byte = data_reg[15:8]; // [R18]
            2'h2:    tx_byte = data_reg[7:0];
            default: tx_byte = `IFCU_FILL_BYTE;
        endcase
    end

    assign addr_hit = (rx_sh_reg[7:1] == tgt_addr);

    // open drain: a zero is driven by enabling the output, a one by releasing it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg      <= ifcu_pkg::ST_IDLE;
            rx_sh_reg      <= 8'h00;
            tx_sh_reg      <= 8'h00;
            bit_cnt_reg    <= 4'h0;
            rw_reg         <= 1'b0;
            first_reg      <= 1'b0;
            tx_idx_reg     <= 2'h0;
            sda_oe_reg     <= 1'b0;
            push_valid_reg <= 1'b0;
            push_data_reg  <= 9'h000;
        end else begin
            push_valid_reg <= 1'b0;
            if (bus_start) begin
                state_reg   <= ifcu_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe_reg  <= 1'b0;
            end else if (bus_stop) begin
                state_reg  <= ifcu_pkg::ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ifcu_pkg::ST_ADDR, ifcu_pkg::ST_RX: begin
                        if (scl_rise) begin
                            rx_sh_reg   <= {rx_sh_reg[6:0], sda_s2_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (state_reg == ifcu_pkg::ST_ADDR) begin
                                if (addr_hit) begin // [R15]
                                    sda_oe_reg <= 1'b1;
                                    rw_reg     <= rx_sh_reg[0];
                                    first_reg  <= 1'b1;
                                    tx_idx_reg <= 2'h0;
                                    state_reg  <= ifcu_pkg::ST_ADDR_ACK;
                                end else begin
                                    state_reg <= ifcu_pkg::ST_IDLE;
                                end
                            end else if (fifo_in_ready) begin
                                // a full fifo answers with no acknowledge
                                sda_oe_reg     <= 1'b1;
                                push_valid_reg <= 1'b1;
                                push_data_reg  <= {first_reg, rx_sh_reg};
                                first_reg      <= 1'b0;
                                state_reg      <= ifcu_pkg::ST_RX_ACK;
                            end else begin
                                state_reg <= ifcu_pkg::ST_IDLE;
                            end
                        end
                    end
                    ifcu_pkg::ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rw_reg) begin
                                sda_oe_reg  <= !tx_byte[7]; // [R19]
                                tx_sh_reg   <= {tx_byte[6:0], 1'b0};
                                tx_idx_reg  <= tx_idx_reg + 2'h1;
                                bit_cnt_reg <= 4'h1;
                                state_reg   <= ifcu_pkg::ST_TX;
                            end else begin
                                sda_oe_reg  <= 1'b0;
                                bit_cnt_reg <= 4'h0;
                                state_reg   <= ifcu_pkg::ST_RX;
                            end
                        end
                    end
                    ifcu_pkg::ST_RX_ACK: begin
                        if (scl_fall) begin
                            sda_oe_reg  <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= ifcu_pkg::ST_RX;
                        end
                    end
                    ifcu_pkg::ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                sda_oe_reg <= 1'b0;
                                state_reg  <= ifcu_pkg::ST_TX_ACK;
                            end else begin
                                sda_oe_reg  <= !tx_sh_reg[7];
                                tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    ifcu_pkg::ST_TX_ACK: begin
                        if (scl_rise && sda_s2_reg) begin
                            state_reg <= ifcu_pkg::ST_IDLE;
                        end else if (scl_fall) begin
                            sda_oe_reg  <= !tx_byte[7];
                            tx_sh_reg   <= {tx_byte[6:0], 1'b0};
                            if (tx_idx_reg != 2'h3) begin
                                tx_idx_reg <= tx_idx_reg + 2'h1;
                            end
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= ifcu_pkg::ST_TX;
                        end
                    end
                    default: begin
                        sda_oe_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // received bytes wait in the fifo while a fetch is in progress
    logic       pop_valid;
    logic [8:0] pop_data;
    logic       pop_ready;

    assign pop_ready = !busy_reg;

    ifcu_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push_valid_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_reg),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // ============================================================
    // word fetch: first byte of a write selects the word, data ready after the wait
    logic [`IFCU_ADDR_W-1:0] word_addr_reg;
    logic [31:0]             fetch_cnt_reg;
    logic                    fetch_go;

    assign fetch_go = pop_valid && pop_ready && pop_data[8];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_reg      <= 1'b0;
            fetch_cnt_reg <= 32'h0;
            word_addr_reg <= '0;
            data_reg      <= 16'h0000;
        end else if (fetch_go) begin
            busy_reg      <= 1'b1; // [R18]
            fetch_cnt_reg <= 32'(FETCH_CYCLES);
            word_addr_reg <= pop_data[`IFCU_ADDR_W-1:0];
        end else if (busy_reg) begin
            fetch_cnt_reg <= fetch_cnt_reg - 32'h1;
            if (fetch_cnt_reg == 32'h1) begin
                busy_reg <= 1'b0;
                data_reg <= store_mem[word_addr_reg]; // [R7]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_o      <= 1'b0;
            sda_oe     <= 1'b0;
            fetch_busy <= 1'b0;
        end else begin
            sda_o      <= 1'b0;
            sda_oe     <= sda_oe_reg;
            fetch_busy <= busy_reg;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_fetch_start;
        fetch_go ##1 busy_reg;
    endsequence

    a_addr_match: assert property ( // [R15]
        (state_reg == ifcu_pkg::ST_ADDR && $past(state_reg) == ifcu_pkg::ST_ADDR
         && scl_fall && bit_cnt_reg == 4'h8 && !bus_start && !bus_stop && addr_hit)
        |=> state_reg == ifcu_pkg::ST_ADDR_ACK && sda_oe_reg)
        else $error("matching address not acknowledged");

    a_addr_source: assert property ( // [R16]
        addr_prog_reg |-> tgt_addr == store_mem[`IFCU_TGT_ADDR_WORD][6:0])
        else $error("programmed address not used");

    a_status_first: assert property ( // [R19]
        (state_reg == ifcu_pkg::ST_ADDR_ACK && scl_fall && rw_reg && !bus_start && !bus_stop)
        |-> tx_idx_reg == 2'h0 ##1 (sda_oe_reg == !status_byte[7] && tx_idx_reg == 2'h1))
        else $error("first read byte is not the status byte");

    a_data_order: assert property ( // [R18]
        (state_reg == ifcu_pkg::ST_TX_ACK && scl_fall && !bus_start && !bus_stop && tx_idx_reg == 2'h1)
        |=> tx_sh_reg == {data_reg[14:8], 1'b0} && sda_oe_reg == !data_reg[15])
        else $error("high data byte not sent second");

    a_fetch_busy: assert property ( // [R18]
        s_fetch_start |-> fetch_cnt_reg == 32'(FETCH_CYCLES) ##1 busy_reg)
        else $error("fetch wait not started");

    a_fetch_count: assert property ( // [R18]
        busy_reg |-> fetch_cnt_reg <= 32'(FETCH_CYCLES) && fetch_cnt_reg != 32'h0)
        else $error("fetch counter out of range");

    a_fetch_latch: assert property ( // [R7]
        $fell(busy_reg) |-> data_reg == store_mem[word_addr_reg])
        else $error("fetched word not latched");

    a_reserved_upper: assert property ( // [R9]
        $past(prog_we) && $past(prog_addr) == `IFCU_CAL_UPPER_T |-> store_mem[`IFCU_CAL_UPPER_T][15:6] == 10'h000)
        else $error("reserved bits of word 4 kept");

    a_reserved_mid: assert property ( // [R10]
        $past(prog_we) && $past(prog_addr) == `IFCU_PRESS_C_MID |-> store_mem[`IFCU_PRESS_C_MID][7:0] == 8'h00)
        else $error("reserved byte of word 0x13 kept");

    a_out_follows: assert property ( // [R14]
        sda_oe_reg |=> sda_oe && !sda_o)
        else $error("data pin not driven low while enabled");
endmodule
`default_nettype wire

// ### verification/ifcu_host_model.sv
// host controller model that drives the serial link of the calibration store
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host model
module ifcu_host_model (
    input  wire logic       clk,
    input  wire logic       sda_wire,
    output logic            scl,
    output logic            sda_low,
    output logic            obs_valid,
    output logic [7:0]      obs_val
);
    int half = 12;
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
        obs_valid = 1'h0;
        obs_val = 8'h00;
    end
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic publish(logic [7:0] v);
        obs_val = v;
        obs_valid = 1'h1;
        tick(1);
        obs_valid = 1'h0;
    endtask
    // also used as repeated start, so scl may already be low
    task automatic start();
        sda_low = 1'h0;
        tick(half);
        scl = 1'h1;
        tick(half);
        sda_low = 1'h1;
        tick(half);
        scl = 1'h0;
        tick(2);
    endtask
    task automatic stop();
        sda_low = 1'h1;
        tick(half);
        scl = 1'h1;
        tick(half);
        sda_low = 1'h0;
        tick(half);
    endtask
    // data moves 2 clk after the clock falls, so it never looks like a start or stop
    task automatic bit_io(input logic b, output logic seen);
        sda_low = ~b;
        tick(half);
        scl = 1'h1;
        tick(half);
        seen = sda_wire;
        scl = 1'h0;
        tick(2);
    endtask
    task automatic wbyte(logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], s);
        end
        bit_io(1'h1, s);
        publish({7'h00, ~s});
    endtask
    // every read byte but the last is acked; the last gets a nack
    task automatic rbyte(logic last);
        logic [7:0] v;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, v[i]);
        end
        bit_io(last, s);
        publish(v);
    endtask
    // raw samples are smoothed before compensation; init or a coefficient of 1 returns the raw sample
    function automatic logic [7:0] smooth(logic [7:0] prev, logic [7:0] raw, logic [4:0] coef, logic init);
        logic [12:0] acc;
        acc = 13'(prev) * 13'(coef - 5'h01) + 13'(raw);
        if (init || coef == 5'h01) return raw;
        return 8'(acc / 13'(coef));
    endfunction
    // 17-bit pressure coefficient h: top bit from word 3 bit 15, reserved bit 14 dropped
    function automatic logic [31:0] unpack_h(logic [15:0] upper, logic [15:0] low);
        logic [16:0] c;
        c = {upper[15], low};
        return 32'(signed'(c));
    endfunction
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the calibration store target
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench
module testbench;
    localparam int FC = 1000;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        adc_powered;
    logic        store_crc_error;
    logic        prog_we;
    logic [4:0]  prog_addr;
    logic [15:0] prog_data;
    logic        sda_o;
    logic        sda_oe;
    logic        fetch_busy;
    logic        scl;
    logic        sda_low;
    logic        obs_valid;
    logic [7:0]  obs_val;
    logic [7:0]  expq[$];
    logic [15:0] mem[32];
    logic [4:0]  last_w;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;
    // pulled-up wire: low when either side pulls it down
    wire logic   sda_wire;
    assign sda_wire = ~((sda_oe & ~sda_o) | sda_low);
    always #5 clk = ~clk;
    ifcu_target_top #(.FETCH_CYCLES(FC), .FIFO_DEPTH(4)) u_dut (
        .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
        .adc_powered(adc_powered), .store_crc_error(store_crc_error), .prog_we(prog_we),
        .prog_addr(prog_addr), .prog_data(prog_data), .fetch_busy(fetch_busy));
    ifcu_host_model u_host (
        .clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low),
        .obs_valid(obs_valid), .obs_val(obs_val));
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            close_out();
        end
    end
    // monitor: every byte or ack seen by the host is matched against the oldest note
    always @(posedge clk) begin
        if (obs_valid === 1'h1) begin
            if (expq.size() == 0) check(obs_val, 8'hXX);
            else check(obs_val, expq.pop_front());
        end
    end
    // reserved bits read back as zero
    function automatic logic [15:0] keep(logic [4:0] a);
        return (a == 5'h03) ? 16'hBFFF : (a == 5'h04) ? 16'h003F : (a == 5'h13) ? 16'hFF00 : 16'hFFFF;
    endfunction
    task automatic prog(logic [4:0] a, logic [15:0] d);
        @(negedge clk);
        prog_we = 1'h1;
        prog_addr = a;
        prog_data = d;
        @(negedge clk);
        prog_we = 1'h0;
    endtask
    task automatic addr_only(logic [7:0] a, logic [7:0] ack);
        expq.push_back(ack);
        u_host.start();
        u_host.wbyte(a);
        u_host.stop();
    endtask
    // skipping the wait reads the previous word with busy set
    task automatic fetch(logic [4:0] w, logic [6:0] dev, logic wait_ok);
        logic [15:0] exp_w;
        exp_w = wait_ok ? mem[w] : mem[last_w];
        expq.push_back(8'h01);
        u_host.start();
        u_host.wbyte({dev, 1'h0});
        expq.push_back(8'h01);
        u_host.wbyte({3'h0, w});
        u_host.stop();
        // the same fixed FC + 10 cycle wait comes before each read with wait_ok set; without it busy is checked instead
        if (wait_ok) u_host.tick(FC + 10);
        else check({7'h00, fetch_busy}, 8'h01);
        expq.push_back(8'h01);
        expq.push_back({1'h0, adc_powered, ~wait_ok, 2'h0, store_crc_error, 2'h0});
        expq.push_back(exp_w[15:8]);
        expq.push_back(exp_w[7:0]);
        u_host.start();
        u_host.wbyte({dev, 1'h1});
        u_host.rbyte(1'h0);
        u_host.rbyte(1'h0);
        u_host.rbyte(1'h1);
        u_host.stop();
        last_w = w;
    endtask
    initial begin
        logic [15:0] d;
        prog_we = 1'h0;
        prog_addr = 5'h00;
        prog_data = 16'h0000;
        void'($urandom(32'hF51050F4));
        adc_powered = 1'($urandom);
        store_crc_error = 1'($urandom);
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        repeat (3) @(negedge clk);
        for (int a = 3; a < 20; a++) begin
            d = 16'($urandom);
            mem[a] = d & keep(5'(a));
            prog(5'(a), d);
        end
        for (int a = 3; a < 20; a++) begin
            u_host.half = (a < 6) ? 25 : 12;
            adc_powered = 1'($urandom);
            store_crc_error = 1'($urandom);
            fetch(5'(a), 7'h78, 1'h1);
        end
        u_host.half = 12;
        fetch(5'h05, 7'h78, 1'h0);
        u_host.tick(FC);
        addr_only(8'hE0, 8'h00);
        prog(5'h02, 16'h12D5);
        addr_only(8'hF0, 8'h00);
        fetch(5'h06, 7'h55, 1'h1);
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        check({7'h00, sda_oe}, 8'h00);
        rst_n = 1'h1;
        repeat (3) @(negedge clk);
        // address override cleared by reset, store contents kept
        fetch(5'h07, 7'h78, 1'h1);
        repeat (4) @(negedge clk);
        // host-side smoothing and coefficient assembly held against fixed rule values
        check(u_host.smooth(8'h40, 8'h80, 5'h02, 1'h0), 8'h60);
        check(u_host.smooth(8'h40, 8'h80, 5'h04, 1'h0), 8'h50);
        check(u_host.smooth(8'h40, 8'h80, 5'h01, 1'h0), 8'h80);
        check(u_host.smooth(8'h60, 8'h80, 5'h02, 1'h0), 8'h70);
        check(u_host.smooth(8'h40, 8'h80, 5'h10, 1'h1), 8'h80);
        check(8'(u_host.unpack_h(16'h8000, 16'h1234) >> 24), 8'hFF);
        check(8'(u_host.unpack_h(16'h4000, 16'h8000) >> 8), 8'h80);
        check(8'(expq.size()), 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
